/* File: flash_seq_pkg.sv */
`default_nettype none
package flash_seq_pkg;
    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 28;
    localparam int SEG_W = 4;
    localparam int SEG_LSB = 24;
    localparam int BLK_W = 12;
    localparam int BLK_LSB = 16;
    localparam logic [12:0] BLK_TOTAL = 13'h1000;
    localparam logic [3:0] LVL_ALL_MIN = 4'hd;
    localparam int OTP_HALF_BIT = 9;

    // ------------------------------------------------------------
    // Register bit positions and reset values
    // ------------------------------------------------------------
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_LVL_LSB = 2;
    localparam int CF_TB = 3;
    localparam int CF_WIDE = 5;
    localparam int SC_FACT = 0;
    localparam int SC_CUST = 1;
    localparam logic [3:0] LVL_RST = 4'h0;
    localparam logic [SEG_W-1:0] SEG_RST = 4'h0;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OPC_WRDI = 8'h04;
    localparam logic [7:0] OPC_RDSR = 8'h05;
    localparam logic [7:0] OPC_RDCR = 8'h15;
    localparam logic [7:0] OPC_WRSR = 8'h01;
    localparam logic [7:0] OPC_RDSEC = 8'h2b;
    localparam logic [7:0] OPC_WRSEC = 8'h2f;
    localparam logic [7:0] OPC_ENSEC = 8'hb1;
    localparam logic [7:0] OPC_EXSEC = 8'hc1;
    localparam logic [7:0] OPC_ENTER_WIDE_ADDR_CMD = 8'hb7;
    localparam logic [7:0] OPC_EXIT_WIDE_ADDR_CMD = 8'he9;
    localparam logic [7:0] OPC_WRSEG = 8'hc5;
    localparam logic [7:0] OPC_RDSEG = 8'hc8;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_READ4 = 8'h13;
    localparam logic [7:0] OPC_PP = 8'h02;
    localparam logic [7:0] OPC_PP4 = 8'h12;
    localparam logic [7:0] OPC_SE = 8'h20;
    localparam logic [7:0] OPC_SE4 = 8'h21;
    localparam logic [7:0] OPC_BE = 8'hd8;
    localparam logic [7:0] OPC_BE4 = 8'hdc;
    localparam logic [7:0] OPC_CE = 8'h60;
    localparam logic [7:0] OPC_CE2 = 8'hc7;

    // ------------------------------------------------------------
    // Byte counts
    // ------------------------------------------------------------
    localparam logic [3:0] LEN_OPC = 4'h1;
    localparam logic [3:0] LEN_NARROW = 4'h3;
    localparam logic [3:0] LEN_WIDE = 4'h4;
    localparam logic [3:0] LEN_MAX = 4'hf;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_PROGRAM = 4'b0001,
        OP_SECTOR = 4'b0010,
        OP_BLOCK = 4'b0100,
        OP_CHIP = 4'b1000
    } op_kind_t;

    typedef enum logic [4:0] {
        LK_CMD = 5'b00001,
        LK_ADDR = 5'b00010,
        LK_DIN = 5'b00100,
        LK_DOUT = 5'b01000,
        LK_STANDBY = 5'b10000
    } link_st_t;
endpackage : flash_seq_pkg
`default_nettype wire

/* File: serial_flash_addr_protect_otp.sv */
`default_nettype none
module serial_flash_addr_protect_otp
    import flash_seq_pkg::*;
(
    // Core clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // Array read port, serial clock domain
    output logic [flash_seq_pkg::ADDR_W-1:0] array_rd_addr,
    output logic array_rd_otp,
    input wire logic [7:0] array_rd_data,
    // Array engine, core clock domain
    input wire logic array_busy,
    input wire logic factory_lock_strap,
    output logic op_start,
    output flash_seq_pkg::op_kind_t op_kind,
    output logic [flash_seq_pkg::ADDR_W-1:0] op_addr,
    output logic op_otp,
    output logic op_refused
);
    import flash_seq_pkg::*;

    // ------------------------------------------------------------
    // Core register state, declared early for the link readback
    // ------------------------------------------------------------
    logic wel_r, wel_nxt;
    logic [3:0] lvl_r, lvl_nxt;
    logic tb_r, tb_nxt;
    logic wide_r, wide_nxt;
    logic [SEG_W-1:0] seg_r, seg_nxt;
    logic cust_r, cust_nxt;
    logic fact_r, fact_nxt;
    logic secure_r, secure_nxt;

    // ------------------------------------------------------------
    // Opcode classes
    // ------------------------------------------------------------
    function automatic logic is_wide_opc(input logic [7:0] o);
        return o == OPC_READ4 || o == OPC_PP4 || o == OPC_SE4 ||
            o == OPC_BE4;
    endfunction : is_wide_opc

    function automatic logic is_addr_opc(input logic [7:0] o);
        return is_wide_opc(o) || o == OPC_READ || o == OPC_PP ||
            o == OPC_SE || o == OPC_BE;
    endfunction : is_addr_opc

    function automatic logic is_regrd_opc(input logic [7:0] o);
        return o == OPC_RDSR || o == OPC_RDCR || o == OPC_RDSEC ||
            o == OPC_RDSEG;
    endfunction : is_regrd_opc

    function automatic logic is_valid_opc(input logic [7:0] o);
        return is_addr_opc(o) || is_regrd_opc(o) || o == OPC_WRITE_ENABLE_CMD ||
            o == OPC_WRDI || o == OPC_WRSR || o == OPC_WRSEC ||
            o == OPC_ENSEC || o == OPC_EXSEC || o == OPC_ENTER_WIDE_ADDR_CMD ||
            o == OPC_EXIT_WIDE_ADDR_CMD || o == OPC_WRSEG || o == OPC_CE ||
            o == OPC_CE2;
    endfunction : is_valid_opc

    // ------------------------------------------------------------
    // Link domain: serial clock, frame bounded by select
    // ------------------------------------------------------------
    logic first_r, out_en_r, out_en_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [3:0] byte_r, byte_nxt;
    logic [7:0] opc_r, opc_nxt;
    logic [31:0] sh_r, sh_nxt;
    link_st_t st_r, st_nxt;
    logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
    logic rd_otp_r, rd_otp_nxt;
    logic busy_m_r, busy_s_r;
    logic [7:0] hold_r;
    logic [7:0] tx_src;
    logic [2:0] bit_cur;
    logic [3:0] byte_cur, alen;
    logic [7:0] opc_full;
    logic [31:0] sh_full;
    link_st_t st_cur;
    logic byte_done;

    // Select high ends the frame; these flops restart from constants
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            first_r <= 1'b1;
            out_en_r <= 1'b0;
        end else begin
            first_r <= 1'b0;
            out_en_r <= out_en_nxt;
        end
    end

    // Capture state stays put after select rises so the core can read it
    always_comb begin
        bit_cur = first_r ? 3'd0 : bit_r;
        byte_cur = first_r ? 4'h0 : byte_r;
        st_cur = first_r ? LK_CMD : st_r;
        byte_done = bit_cur == 3'd7;
        opc_full = {opc_r[6:0], si};
        sh_full = {sh_r[30:0], si};
        alen = (is_wide_opc(opc_r) || wide_r) ? LEN_WIDE : LEN_NARROW;
        bit_nxt = bit_cur + 3'd1;
        byte_nxt = byte_cur;
        if (byte_done && byte_cur != LEN_MAX) begin
            byte_nxt = byte_cur + 4'h1;
        end
        opc_nxt = (st_cur == LK_CMD) ? opc_full : opc_r;
        sh_nxt = sh_r;
        if (st_cur == LK_ADDR ||
            (st_cur == LK_DIN && !is_addr_opc(opc_r) &&
            byte_cur <= 4'h2)) begin
            sh_nxt = sh_full;
        end
        st_nxt = st_cur;
        rd_addr_nxt = rd_addr_r;
        rd_otp_nxt = rd_otp_r;
        case (st_cur)
            LK_CMD: begin
                if (byte_done) begin
                    if (!is_valid_opc(opc_full)) begin
                        st_nxt = LK_STANDBY;
                    end else if (is_regrd_opc(opc_full)) begin
                        st_nxt = LK_DOUT;
                    end else if (is_addr_opc(opc_full)) begin
                        st_nxt = LK_ADDR;
                    end else begin
                        st_nxt = LK_DIN;
                    end
                end
            end
            LK_ADDR: begin
                if (byte_done && byte_cur == alen) begin
                    if (opc_r == OPC_READ || opc_r == OPC_READ4) begin
                        // Reads during a write are dropped, not queued
                        st_nxt = busy_s_r ? LK_STANDBY : LK_DOUT;
                        rd_otp_nxt = secure_r;
                        if (alen == LEN_WIDE) begin
                            rd_addr_nxt = sh_full[ADDR_W-1:0];
                        end else begin
                            rd_addr_nxt = {seg_r, sh_full[23:0]};
                        end
                    end else begin
                        st_nxt = LK_DIN;
                    end
                end
            end
            LK_DOUT: begin
                // Plain increment runs across segments and wraps at top
                if (byte_done) begin
                    rd_addr_nxt = rd_addr_r + 28'h000_0001;
                end
            end
            LK_DIN, LK_STANDBY: begin
                st_nxt = st_cur;
            end
            default: begin
                st_nxt = LK_STANDBY;
            end
        endcase
        out_en_nxt = st_nxt == LK_DOUT;
    end

    always_ff @(posedge sclk) begin
        bit_r <= bit_nxt;
        byte_r <= byte_nxt;
        opc_r <= opc_nxt;
        sh_r <= sh_nxt;
        st_r <= st_nxt;
        rd_addr_r <= rd_addr_nxt;
        rd_otp_r <= rd_otp_nxt;
        busy_m_r <= array_busy;
        busy_s_r <= busy_m_r;
    end

    // Readback source; core registers only change between frames
    always_comb begin
        case (opc_r)
            OPC_RDSR: tx_src = {2'b00, lvl_r, wel_r, busy_s_r};
            OPC_RDCR: tx_src = {2'b00, wide_r, 1'b0, tb_r, 3'b000};
            OPC_RDSEC: tx_src = {6'h00, cust_r, fact_r};
            OPC_RDSEG: tx_src = {4'h0, seg_r};
            default: tx_src = array_rd_data;
        endcase
    end

    // Falling edge shifts out; first bit of each byte takes a fresh source
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            so <= 1'b0;
            so_oe <= 1'b0;
            hold_r <= 8'h00;
        end else begin
            so_oe <= out_en_r;
            if (bit_r == 3'd0) begin
                so <= tx_src[7];
                hold_r <= tx_src;
            end else begin
                so <= hold_r[3'd7 - bit_r];
            end
        end
    end

    assign array_rd_addr = rd_addr_r;
    assign array_rd_otp = rd_otp_r;

    // ------------------------------------------------------------
    // Core domain: frame end detection and command execution
    // ------------------------------------------------------------
    logic cs_m_r, cs_s_r, cs_d_r;
    logic clkd_m_r, clkd_s_r, seen_r, seen_nxt;
    logic strap_m_r, strap_s_r, strap_pend_r;
    logic start_r, start_nxt, refused_r, refused_nxt;
    logic otp_r, otp_nxt;
    op_kind_t kind_r, kind_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic frame_end, aligned, prot_hit, otp_locked, wr_ok, wide_cmd;
    logic [3:0] hdr;
    logic [ADDR_W-1:0] eff;
    logic [12:0] span, blk;
    logic [7:0] d0, d1;

    // Protection window of the addressed 64KB block
    always_comb begin
        blk = {1'b0, eff[BLK_LSB +: BLK_W]};
        span = 13'h0001 << (lvl_r - 4'h1);
        if (lvl_r == LVL_RST) begin
            prot_hit = 1'b0;
        end else if (lvl_r >= LVL_ALL_MIN) begin
            prot_hit = 1'b1;
        end else if (tb_r) begin
            prot_hit = blk < span;
        end else begin
            prot_hit = blk >= BLK_TOTAL - span;
        end
    end

    // Command decode from the frozen capture registers
    always_comb begin
        // Only a frame that clocked counts; a bare select pulse
        // must not replay the stale capture
        frame_end = cs_s_r && !cs_d_r && seen_r;
        aligned = bit_r == 3'd0;
        wide_cmd = is_wide_opc(opc_r) || wide_r;
        hdr = wide_cmd ? 4'h5 : 4'h4;
        d0 = (byte_r == 4'h3) ? sh_r[15:8] : sh_r[7:0];
        d1 = sh_r[7:0];
        if (wide_cmd) begin
            eff = sh_r[ADDR_W-1:0];
        end else begin
            eff = {seg_r, sh_r[23:0]};
        end
        otp_locked = eff[OTP_HALF_BIT] ? fact_r : cust_r;
        wr_ok = frame_end && aligned && wel_r && !array_busy;
        seen_nxt = frame_end ? 1'b0 : (seen_r || clkd_s_r);
        wel_nxt = wel_r;
        lvl_nxt = lvl_r;
        tb_nxt = tb_r;
        wide_nxt = wide_r;
        seg_nxt = seg_r;
        cust_nxt = cust_r;
        fact_nxt = strap_pend_r ? strap_s_r : fact_r;
        secure_nxt = secure_r;
        start_nxt = 1'b0;
        refused_nxt = 1'b0;
        kind_nxt = kind_r;
        addr_nxt = addr_r;
        otp_nxt = otp_r;
        if (frame_end && aligned && byte_r == LEN_OPC) begin
            case (opc_r)
                OPC_WRITE_ENABLE_CMD: wel_nxt = 1'b1;
                OPC_WRDI: wel_nxt = 1'b0;
                OPC_ENSEC: secure_nxt = 1'b1;
                OPC_EXSEC: secure_nxt = 1'b0;
                OPC_ENTER_WIDE_ADDR_CMD: wide_nxt = 1'b1;
                OPC_EXIT_WIDE_ADDR_CMD: wide_nxt = 1'b0;
                default: wel_nxt = wel_r;
            endcase
        end
        if (wr_ok) begin
            if (opc_r == OPC_WRSR &&
                (byte_r == 4'h2 || byte_r == 4'h3)) begin
                lvl_nxt = d0[ST_LVL_LSB +: 4];
                if (byte_r == 4'h3) begin
                    tb_nxt = d1[CF_TB];
                end
                wel_nxt = 1'b0;
            end
            if (opc_r == OPC_WRSEC && byte_r == LEN_OPC) begin
                cust_nxt = 1'b1;
                wel_nxt = 1'b0;
            end
            if (opc_r == OPC_WRSEG && byte_r == 4'h2) begin
                seg_nxt = d0[SEG_W-1:0];
                wel_nxt = 1'b0;
            end
            if (((opc_r == OPC_PP || opc_r == OPC_PP4) && byte_r > hdr) ||
                ((opc_r == OPC_SE || opc_r == OPC_SE4 ||
                opc_r == OPC_BE || opc_r == OPC_BE4) && byte_r == hdr) ||
                ((opc_r == OPC_CE || opc_r == OPC_CE2) &&
                byte_r == LEN_OPC)) begin
                wel_nxt = 1'b0;
                addr_nxt = eff;
                otp_nxt = secure_r;
                case (opc_r)
                    OPC_PP, OPC_PP4: kind_nxt = OP_PROGRAM;
                    OPC_SE, OPC_SE4: kind_nxt = OP_SECTOR;
                    OPC_BE, OPC_BE4: kind_nxt = OP_BLOCK;
                    default: kind_nxt = OP_CHIP;
                endcase
                if (secure_r) begin
                    // Secured mode: only program into an open OTP half
                    if (opc_r == OPC_PP || opc_r == OPC_PP4) begin
                        start_nxt = !otp_locked;
                        refused_nxt = otp_locked;
                    end else begin
                        refused_nxt = 1'b1;
                    end
                end else if (opc_r == OPC_CE || opc_r == OPC_CE2) begin
                    start_nxt = lvl_r == LVL_RST;
                    refused_nxt = lvl_r != LVL_RST;
                end else begin
                    start_nxt = !prot_hit;
                    refused_nxt = prot_hit;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        cs_m_r <= cs_n;
        cs_s_r <= cs_m_r;
        clkd_m_r <= !first_r;
        clkd_s_r <= clkd_m_r;
        strap_m_r <= factory_lock_strap;
        strap_s_r <= strap_m_r;
        if (srst) begin
            cs_d_r <= 1'b1;
            seen_r <= 1'b0;
            strap_pend_r <= 1'b1;
            wel_r <= 1'b0;
            lvl_r <= LVL_RST;
            tb_r <= 1'b0;
            wide_r <= 1'b0;
            seg_r <= SEG_RST;
            cust_r <= 1'b0;
            fact_r <= 1'b0;
            secure_r <= 1'b0;
            start_r <= 1'b0;
            refused_r <= 1'b0;
            kind_r <= OP_PROGRAM;
            addr_r <= '0;
            otp_r <= 1'b0;
        end else begin
            cs_d_r <= cs_s_r;
            seen_r <= seen_nxt;
            strap_pend_r <= 1'b0;
            wel_r <= wel_nxt;
            lvl_r <= lvl_nxt;
            tb_r <= tb_nxt;
            wide_r <= wide_nxt;
            seg_r <= seg_nxt;
            cust_r <= cust_nxt;
            fact_r <= fact_nxt;
            secure_r <= secure_nxt;
            start_r <= start_nxt;
            refused_r <= refused_nxt;
            kind_r <= kind_nxt;
            addr_r <= addr_nxt;
            otp_r <= otp_nxt;
        end
    end

    assign op_start = start_r;
    assign op_refused = refused_r;
    assign op_kind = kind_r;
    assign op_addr = addr_r;
    assign op_otp = otp_r;
endmodule : serial_flash_addr_protect_otp
`default_nettype wire

/* File: flash_seq_assertions.sv */
`default_nettype none
module flash_seq_assertions
    import flash_seq_pkg::*;
(
    // Clocks and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic sclk,
    // Serial link
    input wire logic cs_n,
    input wire logic so,
    input wire logic so_oe,
    // Array engine
    input wire logic array_busy,
    input wire logic op_start,
    input wire flash_seq_pkg::op_kind_t op_kind,
    input wire logic [flash_seq_pkg::ADDR_W-1:0] op_addr,
    input wire logic op_otp,
    input wire logic op_refused
);
    // ----
    // Checks in the core domain
    // ----
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_deselected;
        cs_n [*3];
    endsequence
    sequence s_clk_high;
        (sclk && !cs_n) [*2];
    endsequence
    // Busy age, saturating; long enough to cover the link sync delay
    logic [5:0] busy_cnt_r;
    always_ff @(posedge core_clk) begin
        busy_cnt_r <= !array_busy ? 6'h00 : busy_cnt_r + {5'h0, ~&busy_cnt_r};
    end
    a_start_once: assert property (op_start |=> !op_start)
        else $error("Start pulse held past one cycle");
    a_refuse_once: assert property (op_refused |=> !op_refused)
        else $error("Refusal pulse held past one cycle");
    a_pulse_excl: assert property (!(op_start && op_refused))
        else $error("Start and refusal together");
    a_kind_onehot: assert property ($onehot(op_kind))
        else $error("Operation kind not one-hot");
    // A refusal also reports the kind and address it turned down
    a_op_hold: assert property (!op_start && !op_refused |->
        $stable(op_kind) && $stable(op_addr) && $stable(op_otp))
        else $error("Operation fields moved without an outcome");
    a_quiet_idle: assert property (s_deselected |-> !so_oe && !so)
        else $error("Output driven while deselected");
    a_shift_fall: assert property (s_clk_high |-> $stable(so))
        else $error("Output changed while serial clock high");
    a_busy_blocks: assert property (
        busy_cnt_r == 6'h3f |-> !op_start)
        else $error("Operation started while engine busy");
    a_act_after_rise: assert property ((op_start || op_refused)
        |-> cs_n && $past(cs_n, 3))
        else $error("Operation outcome before select rose");
endmodule : flash_seq_assertions

bind serial_flash_addr_protect_otp flash_seq_assertions u_chk (
    .core_clk(core_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .so(so),
    .so_oe(so_oe), .array_busy(array_busy), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .op_otp(op_otp),
    .op_refused(op_refused)
);
`default_nettype wire

/* File: flash_host_model.sv */
`default_nettype none
module flash_host_model (
    // Serial link toward the device
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam real HALF = 62.5;
    logic idle_hi;
    // Clock idles low (mode 0) or high (mode 3), still between frames
    initial begin
        idle_hi = 1'b0;
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Mode change while deselected; settles before the next frame
    task automatic set_idle(input logic m);
        idle_hi = m;
        sclk = m;
        #(2 * HALF);
    endtask : set_idle
    // One input bit, set while clock low, taken on the rise
    task automatic tick(input logic v);
        if (idle_hi) #HALF sclk = 1'b0;
        si = v;
        #HALF sclk = 1'b1;
        if (!idle_hi) #HALF sclk = 1'b0;
    endtask : tick
    // Bytes out MSB first, optional stray bits, then read bits
    task automatic frame(input logic [7:0] tx[$], input int stray,
                         input int nrd, output logic [15:0] rx,
                         output logic oe);
        rx = '0;
        oe = 1'b0;
        cs_n = 1'b0;
        foreach (tx[i])
            for (int b = 7; b >= 0; b--)
                tick(tx[i][b]);
        repeat (stray) tick(1'b0);
        for (int b = 0; b < nrd; b++) begin
            if (idle_hi) #HALF sclk = 1'b0;
            #HALF sclk = 1'b1;
            rx = {rx[14:0], so};
            oe = oe | so_oe;
            if (!idle_hi) #HALF sclk = 1'b0;
        end
        #HALF cs_n = 1'b1;
        si = ~si;
        #600;
    endtask : frame
endmodule : flash_host_model
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_seq_pkg::*;
    typedef logic [7:0] bq_t[$];
    logic core_clk, srst, sclk, cs_n, si, so, so_oe, oe, factory_lock_strap;
    logic array_rd_otp, array_busy, op_start, op_otp, op_refused;
    logic [ADDR_W-1:0] array_rd_addr, op_addr, evt_a, a;
    logic [7:0] array_rd_data;
    logic [15:0] rx;
    op_kind_t op_kind;
    int err_total, n_checks, evt, cyc, lim, blk;
    // Array contents model, a fixed function of the address
    function automatic logic [7:0] mem(input logic [27:0] x);
        return x[7:0] ^ x[27:20] ^ 8'h5a;
    endfunction : mem
    assign array_rd_data = mem(array_rd_addr);
    serial_flash_addr_protect_otp DUT (.core_clk(core_clk), .srst(srst),
        .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
        .array_rd_addr(array_rd_addr), .array_rd_otp(array_rd_otp),
        .array_rd_data(array_rd_data), .array_busy(array_busy),
        .factory_lock_strap(factory_lock_strap), .op_start(op_start),
        .op_kind(op_kind), .op_addr(op_addr), .op_otp(op_otp),
        .op_refused(op_refused));
    flash_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
        .so_oe(so_oe));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Outcome capture and run limit
    always @(posedge core_clk) begin
        cyc++;
        if (op_start) begin
            evt = 1;
            evt_a = op_addr;
        end
        if (op_refused) evt = 2;
        if (cyc == 30000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %0t read %h not %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk_op(input int e, input logic [27:0] ea);
        n_checks++;
        if (evt != e || (e == 1 && evt_a !== ea)) begin
            err_total++;
            $display("FAIL %0t op %0d at %h not %0d", $time, evt, evt_a, e);
        end
    endtask : chk_op
    task automatic cmd(input bq_t q, input int nrd);
        evt = 0;
        host.frame(q, 0, nrd, rx, oe);
    endtask : cmd
    // Opcode plus big-endian address, three or four bytes
    function automatic bq_t aq(input logic [7:0] o, input logic [27:0] x,
                               input int n4);
        bq_t q;
        q = {o, x[23:16], x[15:8], x[7:0]};
        if (n4 != 0) q.insert(1, {4'h0, x[27:24]});
        return q;
    endfunction : aq
    task automatic wop(input bq_t q, input int e, input logic [27:0] ea);
        cmd('{OPC_WRITE_ENABLE_CMD}, 0);
        cmd(q, 0);
        chk_op(e, ea);
    endtask : wop
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // ----
    // Main sequence
    // ----
    initial begin
        srst = 1'b1;
        array_busy = 1'b0;
        factory_lock_strap = 1'b1;
        void'($urandom(32'he3a8_461a));
        repeat (2) @(posedge core_clk);
        #5 srst = 1'b0;
        repeat (6) @(posedge core_clk);
        cmd('{OPC_RDSEC}, 8);
        chk8(rx[7:0], 8'h01);
        cmd('{OPC_RDSEG}, 8);
        chk8(rx[7:0], 8'h00);
        cmd('{8'hff}, 8);
        chk8({7'h0, oe}, 8'h00);
        host.frame('{OPC_WRITE_ENABLE_CMD}, 1, 0, rx, oe);
        cmd('{OPC_RDSR}, 8);
        chk8(rx[7:0], 8'h00);
        cmd('{OPC_WRITE_ENABLE_CMD}, 0);
        cmd('{OPC_RDSR}, 8);
        chk8(rx[7:0], 8'h02);
        cmd('{OPC_WRSEG, 8'hf3}, 0);
        cmd('{OPC_RDSEG}, 8);
        chk8(rx[7:0], 8'h03);
        cmd(aq(OPC_READ, 28'h0ff_ffff, 0), 16);
        chk8(rx[15:8], mem(28'h3ff_ffff));
        chk8(rx[7:0], mem(28'h400_0000));
        cmd('{OPC_RDSEG}, 8);
        chk8(rx[7:0], 8'h03);
        cmd(aq(OPC_READ4, 28'hfff_ffff, 1), 16);
        chk8(rx[15:8], mem(28'hfff_ffff));
        chk8(rx[7:0], mem(28'h000_0000));
        host.set_idle(1'b1);
        a = 28'($urandom);
        wop(aq(OPC_SE, a, 0), 1, {4'h3, a[23:0]});
        cmd('{OPC_ENTER_WIDE_ADDR_CMD}, 0);
        cmd('{OPC_RDCR}, 8);
        chk8(rx[7:0] & 8'h20, 8'h20);
        wop(aq(OPC_BE, a, 1), 1, a);
        cmd('{OPC_EXIT_WIDE_ADDR_CMD}, 0);
        cmd('{OPC_RDCR}, 8);
        chk8(rx[7:0] & 8'h20, 8'h00);
        @(posedge core_clk);
        #5 array_busy = 1'b1;
        repeat (70) @(posedge core_clk);
        wop(aq(OPC_SE4, a, 1), 0, a);
        cmd(aq(OPC_READ, a, 0), 8);
        chk8({7'h0, oe}, 8'h00);
        @(posedge core_clk);
        #5 array_busy = 1'b0;
        cmd('{OPC_WRSEG, 8'h00}, 0);
        cmd('{OPC_ENSEC}, 0);
        wop({aq(OPC_PP, 28'h200, 0), 8'ha5}, 2, 0);
        wop({aq(OPC_PP, 28'h010, 0), 8'ha5}, 1, 28'h010);
        wop('{OPC_WRSEC}, 0, 0);
        cmd('{OPC_RDSEC}, 8);
        chk8(rx[7:0], 8'h03);
        wop({aq(OPC_PP, 28'h010, 0), 8'ha5}, 2, 0);
        wop(aq(OPC_SE, 28'h010, 0), 2, 0);
        cmd('{OPC_EXSEC}, 0);
        for (int l = 0; l < 16; l++) begin
            wop('{OPC_WRSR, {2'b00, 4'(l), 2'b00}, 8'h08}, 0, 0);
            lim = (l == 0) ? 0 : (l > 12) ? 4096 : 1 << (l - 1);
            for (int k = 0; k < 2; k++) begin
                blk = (k != 0) ? lim : lim - 1;
                if (blk < 0 || blk > 4095) blk = $urandom % 4096;
                a = {blk[11:0], 16'($urandom)};
                wop(aq(OPC_SE4, a, 1), (blk < lim) ? 2 : 1, a);
            end
        end
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
